// ===== logic/smem_regs.vh
// Constants for the two-wire serial memory slave
`ifndef SMEM_REGS_VH
`define SMEM_REGS_VH
`define SMEM_ADDR_W      13
`define SMEM_DEPTH       8192
`define SMEM_ADDR_LAST   13'h1fff
`define SMEM_ADDR_RST    13'h0000
`define SMEM_TYPE_MSB    7
`define SMEM_TYPE_LSB    4
`define SMEM_SEL_MSB     3
`define SMEM_SEL_LSB     1
`define SMEM_RW_BIT      0
`define SMEM_BITS_BYTE   4'h8
`define SMEM_FIFO_W      8
`define SMEM_FIFO_D      16
`define SMEM_FIFO_AW     4
`endif

// ===== logic/smem_fifo.v
// Holds no logic; the stream FIFO module sits in smem_slave.v beside its only user

// ===== logic/smem_slave.v
// Two-wire serial slave front end of an 8K byte memory
`timescale 1ns/100ps
`include "smem_regs.vh"
module smem_slave #(
	parameter [3:0] DEV_TYPE = 4'h5 // Arbitrary type code
) (
	// Clock and reset
	input  wire       clk,
	input  wire       nrst,
	// Serial bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	// Straps
	input  wire [2:0] device_select_pins,
	input  wire       wp_in,
	// Write data stream to a consumer
	output wire       wr_valid,
	input  wire       wr_ready,
	output wire [7:0] wr_byte,
	// Status
	output reg  [12:0] addr_out_reg,
	output reg         busy_reg
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_DEV   = 3'h1;
	localparam ST_AHI   = 3'h2;
	localparam ST_ALO   = 3'h3;
	localparam ST_WDATA = 3'h4;
	localparam ST_RDATA = 3'h5;
	localparam ST_RACK  = 3'h6;

	reg        rs1_reg;
	reg        rst_sync_reg;
	wire       rst_n;
	reg        scl1_reg;
	reg        scl2_reg;
	reg        scl3_reg;
	reg        sda1_reg;
	reg        sda2_reg;
	reg        sda3_reg;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;
	reg  [7:0] mem [0:`SMEM_DEPTH-1];
	reg  [2:0] st_reg;
	reg  [3:0] bit_reg;
	reg  [7:0] sh_reg;
	reg  [12:0] addr_reg;
	reg  [4:0] ahi_reg;
	reg        ack_reg;
	reg        drv_reg;
	reg        mem_we;
	reg  [7:0] rd_reg;
	reg        push_reg;
	reg  [7:0] push_data_reg;
	reg  [12:0] wa_reg;
	reg        wp1_reg;
	reg        wp2_reg;
	reg  [2:0] sel1_reg;
	reg  [2:0] sel2_reg;
	wire       fifo_in_ready;
	function [12:0] addr_inc; // Width alone rolls 1fff over to 0000
		input [12:0] a;
		addr_inc = a + 13'h0001;
	endfunction

	// Reset release through two flops
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rs1_reg      <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rs1_reg      <= 1'b1;
			rst_sync_reg <= rs1_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// Pins pass two flops; third stage only for edge finding
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl1_reg <= 1'b1;
			scl2_reg <= 1'b1;
			scl3_reg <= 1'b1;
			sda1_reg <= 1'b1;
			sda2_reg <= 1'b1;
			sda3_reg <= 1'b1;
			wp1_reg  <= 1'b0;
			wp2_reg  <= 1'b0;
			sel1_reg <= 3'h0;
			sel2_reg <= 3'h0;
		end
		else
		begin
			scl1_reg <= scl_in;
			scl2_reg <= scl1_reg;
			scl3_reg <= scl2_reg;
			sda1_reg <= sda_in;
			sda2_reg <= sda1_reg;
			sda3_reg <= sda2_reg;
			wp1_reg  <= wp_in;
			wp2_reg  <= wp1_reg;
			sel1_reg <= device_select_pins;
			sel2_reg <= sel1_reg;
		end
	end

	assign scl_rise  = scl2_reg & ~scl3_reg;
	assign scl_fall  = ~scl2_reg & scl3_reg;
	assign start_det = scl2_reg & scl3_reg & sda3_reg & ~sda2_reg;
	assign stop_det  = scl2_reg & scl3_reg & ~sda3_reg & sda2_reg;

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = drv_reg;

	// Array write is immediate, so no busy polling is ever needed
	always @(posedge clk)
	begin
		if (mem_we)
			mem[wa_reg] <= push_data_reg;
	end

	always @(posedge clk)
	begin
		rd_reg <= mem[addr_reg];
	end

	// Main sequencer; mem_we is a single-cycle strobe
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg        <= ST_IDLE;
			bit_reg       <= 4'h0;
			sh_reg        <= 8'h00;
			addr_reg      <= `SMEM_ADDR_RST;
			wa_reg        <= `SMEM_ADDR_RST;
			ahi_reg       <= 5'h00;
			ack_reg       <= 1'b0;
			drv_reg       <= 1'b0;
			mem_we        <= 1'b0;
			push_reg      <= 1'b0;
			push_data_reg <= 8'h00;
			addr_out_reg  <= `SMEM_ADDR_RST;
			busy_reg      <= 1'b0;
		end
		else
		begin
			mem_we       <= 1'b0;
			push_reg     <= 1'b0;
			addr_out_reg <= addr_reg;
			busy_reg     <= (st_reg != ST_IDLE);
			if (start_det)
			begin
				st_reg  <= ST_DEV;
				bit_reg <= 4'h0;
				ack_reg <= 1'b0;
				drv_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				st_reg  <= ST_IDLE;
				ack_reg <= 1'b0;
				drv_reg <= 1'b0;
			end
			else if (st_reg == ST_RDATA || st_reg == ST_RACK)
			begin
				if (st_reg == ST_RDATA && scl_fall)
				begin
					// Shift out on falling edge
					if (ack_reg)
					begin
						// Address ack ends; first bit comes from the latch
						ack_reg <= 1'b0;
						drv_reg <= ~rd_reg[7];
						sh_reg  <= {rd_reg[6:0], 1'b0};
						bit_reg <= 4'h1;
					end
					else if (bit_reg == `SMEM_BITS_BYTE)
					begin
						drv_reg <= 1'b0; // Release for master ack
						st_reg  <= ST_RACK;
					end
					else
					begin
						drv_reg <= ~sh_reg[7];
						sh_reg  <= {sh_reg[6:0], 1'b0};
						bit_reg <= bit_reg + 4'h1;
						if (bit_reg == 4'h7)
							addr_reg <= addr_inc(addr_reg);
					end
				end
				else if (st_reg == ST_RACK && scl_rise)
				begin
					if (sda2_reg)
						st_reg <= ST_IDLE;
					else
					begin
						st_reg  <= ST_RDATA;
						bit_reg <= 4'h0;
						sh_reg  <= rd_reg;
					end
				end
			end
			else if (st_reg != ST_IDLE)
			begin
				if (scl_rise && !ack_reg)
				begin
					sh_reg  <= {sh_reg[6:0], sda2_reg};
					bit_reg <= bit_reg + 4'h1;
				end
				else if (scl_fall && ack_reg)
				begin
					// End of the ack slot
					ack_reg <= 1'b0;
					drv_reg <= 1'b0;
					bit_reg <= 4'h0;
				end
				else if (scl_fall && bit_reg == `SMEM_BITS_BYTE)
				begin
					ack_reg <= 1'b1;
					case (st_reg)
						ST_DEV:
						begin
							if (sh_reg[`SMEM_TYPE_MSB:`SMEM_TYPE_LSB] == DEV_TYPE
							    && sh_reg[`SMEM_SEL_MSB:`SMEM_SEL_LSB] == sel2_reg)
							begin
								drv_reg <= 1'b1;
								if (sh_reg[`SMEM_RW_BIT])
									st_reg <= ST_RDATA;
								else
									st_reg <= ST_AHI;
							end
							else
							begin
								ack_reg <= 1'b0;
								st_reg  <= ST_IDLE;
							end
						end
						ST_AHI:
						begin
							ahi_reg <= sh_reg[4:0];
							drv_reg <= 1'b1;
							st_reg  <= ST_ALO;
						end
						ST_ALO:
						begin
							addr_reg <= {ahi_reg, sh_reg};
							drv_reg  <= 1'b1;
							st_reg   <= ST_WDATA;
						end
						ST_WDATA:
						begin
							if (wp2_reg)
							begin
								ack_reg <= 1'b0;
								st_reg  <= ST_IDLE;
							end
							else if (!fifo_in_ready)
							begin
								ack_reg <= 1'b0; // Full stream refuses the byte
								st_reg  <= ST_IDLE;
							end
							else
							begin
								mem_we        <= 1'b1;
								push_reg      <= 1'b1;
								push_data_reg <= sh_reg;
								wa_reg        <= addr_reg;
								addr_reg      <= addr_inc(addr_reg);
								drv_reg       <= 1'b1;
							end
						end
						default:
						begin
							ack_reg <= 1'b0;
							st_reg  <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// Copy of written bytes to the consumer; back-pressure refuses the ack
	smem_fifo #(
		.W  (`SMEM_FIFO_W),
		.D  (`SMEM_FIFO_D),
		.AW (`SMEM_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_reg),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_byte)
	);
endmodule // smem_slave

module smem_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	// Clock and reset
	input  wire          clk,
	input  wire          rst_n,
	// Fill side
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	// Drain side
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wp_reg;
	reg  [AW-1:0] rp_reg;
	reg  [AW:0]   cnt_reg;
	wire          push;
	wire          pop;

	assign in_ready  = (cnt_reg != D[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rp_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk)
	begin
		if (push)
			mem[wp_reg] <= in_data;
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // smem_fifo

// ===== dv/smem_master.sv
// Bus master model for the serial link
`timescale 1ns/100ps
module smem_master (
	// Clock and bus
	input  wire clk,
	input  wire sda,
	output reg  scl = 1'b1,
	output reg  pull = 1'b0
);
	// Half of the 80 ns link period
	task hp;
		repeat (4) @(negedge clk);
	endtask
	// Data moves with clock low, taken late in the high phase
	task bitx(input logic b, output logic r);
		pull = !b;
		hp;
		scl = 1'b1;
		hp;
		r = sda;
		scl = 1'b0;
	endtask
	// Same path from idle and as a repeated start
	task start;
		pull = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		pull = 1'b1;
		hp;
		scl = 1'b0;
	endtask
	task stop;
		pull = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		pull = 1'b0;
		hp;
	endtask
	// Ones leave the line to the slave; ninth is the ack
	task xbyte(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bitx(w[i], r[i]);
	endtask
endmodule // smem_master

// ===== dv/smem_slave_properties.sv
// Pin-level assertions for the serial memory slave
`timescale 1ns/100ps
module smem_slave_properties (
	// Clock and reset
	input wire        clk,
	input wire        nrst,
	// Pins and straps
	input wire        scl_in,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe,
	input wire [2:0]  device_select_pins,
	input wire        wp_in,
	// Stream and status
	input wire        wr_valid,
	input wire        wr_ready,
	input wire [7:0]  wr_byte,
	input wire [12:0] addr_out_reg,
	input wire        busy_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence
	sequence start_seen;
		scl_in && $fell(sda_in);
	endsequence
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("pin driven high");
	drive_clock_low_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
		else $error("drive moved late");
	wrap_zero_a: assert property ($past(addr_out_reg) == 13'h1fff && $changed(addr_out_reg)
		|-> addr_out_reg == 13'h0000)
		else $error("no rollover");
	protect_push_a: assert property ($rose(wr_valid) |-> !wp_in && !$past(wp_in))
		else $error("stored while protected");
	fifo_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte))
		else $error("byte lost");
	push_ack_a: assert property ($rose(wr_valid) |-> sda_oe && $past(sda_oe))
		else $error("no ack");
	stop_idle_a: assert property (stop_seen |-> ##[1:8] !busy_reg)
		else $error("busy after stop");
	start_quiet_a: assert property (start_seen |=> !sda_oe [*6])
		else $error("drive after start");
endmodule // smem_slave_properties
bind smem_slave smem_slave_properties u_props (
	.clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .device_select_pins(device_select_pins), .wp_in(wp_in),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_byte(wr_byte),
	.addr_out_reg(addr_out_reg), .busy_reg(busy_reg)
);

// ===== dv/testbench.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
module testbench;
	localparam [3:0] type_code = 4'h5; // Arbitrary, as in the slave
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  sel = 3'h6;
	logic        wp = 1'b0;
	logic        wr_ready = 1'b0;
	logic [7:0]  d;
	logic [8:0]  r;
	integer      bad_count = 0;
	integer      total_checks = 0;
	wire         scl;
	wire         pull;
	wire         sda_out;
	wire         sda_oe;
	wire         wr_valid;
	wire [7:0]   wr_byte;
	wire [12:0]  addr;
	wire         busy;
	// Open drain with pull-up
	wire         sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	smem_master u_master (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
	smem_slave #(.DEV_TYPE(type_code)) u_dut (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .device_select_pins(sel), .wp_in(wp), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_byte(wr_byte), .addr_out_reg(addr), .busy_reg(busy)
	);
	always #5 clk = ~clk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("%0d checks, %0d mismatches", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wb(input logic [7:0] b, input logic nak);
		u_master.xbyte({b, 1'b1}, r);
		chk(r[0], nak);
	endtask
	task head(input logic [15:0] a);
		u_master.start;
		wb({type_code, sel, 1'b0}, 1'b0);
		wb(a[15:8], 1'b0);
		wb(a[7:0], 1'b0);
	endtask
	task sc_fill_wrap;
		head(16'hfffe);
		for (d = 8'h30; d < 8'h41; d++)
			wb(d, d == 8'h40); // Full buffer refuses
		u_master.stop;
		chk(addr, 13'h000e);
		for (d = 8'h30; d < 8'h40; d++)
		begin
			chk({wr_valid, wr_byte}, {1'b1, d});
			wr_ready = 1'b1;
			@(negedge clk);
			wr_ready = 1'b0;
		end
		chk(wr_valid, 1'b0);
	endtask
	task sc_random_read;
		head(16'h1ffe);
		chk(addr, 13'h1ffe);
		u_master.start;
		wb({type_code, sel, 1'b1}, 1'b0);
		for (d = 8'h30; d < 8'h33; d++)
		begin
			u_master.xbyte({8'hff, d == 8'h32}, r);
			chk(r[8:1], d);
		end
		repeat (6) @(negedge clk);
		chk(sda, 1'b1); // Line left free after the last byte
		u_master.stop;
		chk(addr, 13'h0001);
		chk(busy, 1'b0);
	endtask
	task sc_refuse;
		u_master.start;
		wb({type_code, ~sel, 1'b0}, 1'b1);
		wb(8'h00, 1'b1); // Ignored until next start
		u_master.start;
		wb({type_code ^ 4'h3, sel, 1'b1}, 1'b1);
		wp = 1'b1;
		head(16'h0005);
		wb(8'h77, 1'b1);
		u_master.stop;
		wp = 1'b0;
		chk(addr, 13'h0005);
		chk(wr_valid, 1'b0);
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (8) @(negedge clk);
		sc_fill_wrap;
		sc_random_read;
		sc_refuse;
		close_out;
	end
endmodule // testbench
